// ===== rtl/xfer_classifier.sv
// Bus transfer classifier and sequencer for the processor's bus master port.
`default_nettype none
`include "xfer_cfg.svh"
module xfer_classifier (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire xfer_pkg::xfer_req_s req,
	output logic req_ready,
	output logic req_done,
	input wire logic bus_grant_in,
	input wire logic beat_done_in,
	input wire logic wrapper_mode,
	input wire logic slave_test,
	input wire logic slave_select,
	output logic slave_ack,
	output xfer_pkg::bus_out_s bus
);
	// ************************************************************
	// Classification
	// ************************************************************
	// Decode of one request kind into its bus signature.
	typedef struct packed {
		logic [1:0] hint;
		logic write;
		logic data;
		logic forced_priv;
		logic [1:0] fprot;
		logic [3:0] beats;
		logic [4:0] offs;
		logic line;
		logic pen;
	} class_s;

	function automatic class_s classify(input xfer_pkg::xfer_req_s r);
		class_s c;
		c = '{hint: `HINT_NONE, write: 1'b0, data: 1'b1, forced_priv: 1'b0,
			fprot: `PROT_PRIV_DATA, beats: 4'h1, offs: 5'h00, line: 1'b0, pen: 1'b0};
		case (r.kind)
			xfer_pkg::k_fetch_nc: c.data = 1'b0;
			xfer_pkg::k_load_nc: c.beats = r.nwords;
			xfer_pkg::k_store_nb: begin
				c.write = 1'b1;
				c.beats = r.nwords;
				c.pen = 1'b1;
			end
			xfer_pkg::k_store_b: begin
				c.write = 1'b1;
				c.hint = `HINT_SINGLE;
				c.beats = r.nwords;
			end
			xfer_pkg::k_line_i, xfer_pkg::k_line_d: begin
				c.hint = `HINT_LINE8;
				c.data = (r.kind == xfer_pkg::k_line_d);
				c.beats = `LINE_BEATS;
				c.line = 1'b1;
			end
			xfer_pkg::k_evict_lo, xfer_pkg::k_evict_hi: begin
				c.write = 1'b1;
				c.hint = `HINT_WB4;
				c.beats = `HALF_BEATS;
				c.line = 1'b1;
				c.offs = (r.kind == xfer_pkg::k_evict_hi) ? `HALF_OFFSET : 5'h00;
				c.forced_priv = 1'b1;
			end
			xfer_pkg::k_evict_all: begin
				c.write = 1'b1;
				c.hint = `HINT_LINE8;
				c.beats = `LINE_BEATS;
				c.line = 1'b1;
				c.forced_priv = 1'b1;
			end
			xfer_pkg::k_swap: c.pen = 1'b1;
			xfer_pkg::k_walk_i, xfer_pkg::k_walk_d: begin
				c.hint = `HINT_SINGLE;
				c.forced_priv = 1'b1;
				c.fprot = (r.kind == xfer_pkg::k_walk_i) ? `PROT_PRIV_FETCH
					: `PROT_PRIV_DATA;
			end
			default: c.beats = 4'h1;
		endcase
		if (c.beats == 4'h0) begin
			c.beats = 4'h1;
		end
		return c;
	endfunction

	// ************************************************************
	// Sequencer state
	// ************************************************************
	xfer_pkg::seq_state_e state_ff, nxt_state; // Phase of the current transfer.
	logic [1:0] hint_ff, nxt_hint; // Length hint, held until the next transfer.
	logic [1:0] prot_ff, nxt_prot; // Protection bits.
	logic write_ff, nxt_write; // Direction of the transfer.
	logic lock_ff, nxt_lock; // Keeps a swap's two halves together.
	logic pen_ff, nxt_pen; // Wrapper penalty owed per beat.
	logic swap_rd_ff, nxt_swap_rd; // Read half of a swap in progress.
	logic slave_ack_ff, nxt_slave_ack; // Slave answer in test mode.
	logic done_ff, nxt_done; // Completion pulse to the core.
	class_s cls;
	logic take; // Request accepted this cycle.
	logic beat_end; // Current beat finished on the bus.
	logic gen_load;
	logic [31:0] gen_base;
	logic [3:0] gen_beats;
	logic gen_last;
	logic [31:0] addr_w;

	assign cls = classify(req);
	// Slave test mode never starts a master transfer.
	assign req_ready = (state_ff == xfer_pkg::st_idle) && !slave_test;
	assign take = req_valid && req_ready;
	assign beat_end = (state_ff == xfer_pkg::st_beat) && bus_grant_in && beat_done_in;

	// ************************************************************
	// Next-state logic
	// ************************************************************
	// The penalty cycle is only spent behind the wrapper; a plain bus pays nothing.
	always_comb begin
		logic advance;
		advance = 1'b0;
		nxt_state = state_ff;
		nxt_hint = hint_ff;
		nxt_prot = prot_ff;
		nxt_write = write_ff;
		nxt_lock = lock_ff;
		nxt_pen = pen_ff;
		nxt_swap_rd = swap_rd_ff;
		nxt_done = 1'b0;
		nxt_slave_ack = slave_test && slave_select;
		gen_load = 1'b0;
		gen_base = addr_w;
		gen_beats = 4'h1;
		case (state_ff)
			xfer_pkg::st_idle: begin
				if (take) begin
					nxt_state = xfer_pkg::st_addr;
					nxt_hint = cls.hint;
					nxt_write = cls.write;
					nxt_prot = cls.forced_priv ? cls.fprot : {req.priv, cls.data};
					nxt_lock = (req.kind == xfer_pkg::k_swap);
					nxt_swap_rd = (req.kind == xfer_pkg::k_swap);
					nxt_pen = cls.pen && wrapper_mode;
					gen_load = 1'b1;
					gen_beats = cls.beats;
					gen_base = cls.line ? {req.addr[31:5], cls.offs} : req.addr;
					// Buffered stores are posted: the core resumes at once.
					nxt_done = (req.kind == xfer_pkg::k_store_b);
				end
			end
			xfer_pkg::st_addr: begin
				if (bus_grant_in) begin
					nxt_state = xfer_pkg::st_beat;
				end
			end
			xfer_pkg::st_beat: begin
				if (beat_end) begin
					if (pen_ff) begin
						nxt_state = xfer_pkg::st_pen;
					end else begin
						advance = 1'b1;
					end
				end
			end
			xfer_pkg::st_pen: advance = 1'b1;
			default: nxt_state = xfer_pkg::st_idle;
		endcase
		if (advance) begin
			if (!gen_last) begin
				nxt_state = xfer_pkg::st_beat;
			end else if (swap_rd_ff) begin
				// Write half of the swap reuses the read address, still locked.
				nxt_state = xfer_pkg::st_addr;
				nxt_write = 1'b1;
				nxt_swap_rd = 1'b0;
				gen_load = 1'b1;
				gen_base = addr_w;
			end else begin
				nxt_state = xfer_pkg::st_idle;
				nxt_lock = 1'b0;
				nxt_done = (hint_ff != `HINT_SINGLE) || !write_ff;
			end
		end
	end

	// Registers only.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= xfer_pkg::st_idle;
			hint_ff <= `HINT_NONE;
			prot_ff <= 2'h0;
			write_ff <= 1'b0;
			lock_ff <= 1'b0;
			pen_ff <= 1'b0;
			swap_rd_ff <= 1'b0;
			slave_ack_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			hint_ff <= nxt_hint;
			prot_ff <= nxt_prot;
			write_ff <= nxt_write;
			lock_ff <= nxt_lock;
			pen_ff <= nxt_pen;
			swap_rd_ff <= nxt_swap_rd;
			slave_ack_ff <= nxt_slave_ack;
			done_ff <= nxt_done;
		end
	end

	// Address and beat counting live in their own small module.
	beat_addr_gen #(.CNT_W(4)) u_gen (
		.mclk(mclk),
		.rst_n(rst_n),
		.load(gen_load),
		.base(gen_base),
		.beats(gen_beats),
		.step(beat_end && !pen_ff || state_ff == xfer_pkg::st_pen),
		.addr_ff(addr_w),
		.last(gen_last)
	);

	// ************************************************************
	// Outputs
	// ************************************************************
	// Strobe marks the address phase; the lock relies on the arbiter holding off others.
	assign bus.address_strobe_out = (state_ff == xfer_pkg::st_addr);
	assign bus.addr = addr_w;
	assign bus.write_direction_out = write_ff;
	assign bus.hint = hint_ff;
	assign bus.protection_out = prot_ff;
	assign bus.lock = lock_ff;
	assign bus.more_words_pending = (state_ff != xfer_pkg::st_idle) && !gen_last;
	assign slave_ack = slave_ack_ff;
	assign req_done = done_ff;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	store_hint_a: assert property (take && req.kind == xfer_pkg::k_store_b |=> bus.hint == 2'h3
		&& req_done) else $error("buffered store hint or early done wrong");
	nb_store_a: assert property (take && req.kind == xfer_pkg::k_store_nb |=> bus.hint == 2'h0
		&& bus.write_direction_out) else $error("nonbuffered store hint wrong");
	line_start_a: assert property (take && (req.kind == xfer_pkg::k_line_i
		|| req.kind == xfer_pkg::k_line_d) |=> bus.hint == 2'h2 && bus.addr[4:0] == 5'h00)
		else $error("linefill hint or start offset wrong");
	beat_step_a: assert property (beat_end && !pen_ff && !gen_last |=>
		bus.addr == $past(bus.addr) + 32'h4) else $error("burst step not four");
	evict_hi_a: assert property (take && req.kind == xfer_pkg::k_evict_hi |=>
		bus.addr[4:0] == 5'h10 && bus.hint == 2'h1 && bus.protection_out == 2'h3)
		else $error("high half eviction wrong");
	walk_prot_a: assert property (take && req.kind == xfer_pkg::k_walk_i |=>
		bus.hint == 2'h3 && bus.protection_out == 2'h2) else $error("walk class wrong");
	hint_hold_a: assert property (!take |=> $stable(bus.hint))
		else $error("hint moved without a new transfer");
	swap_lock_a: assert property (bus.address_strobe_out && bus.write_direction_out
		&& $past(swap_rd_ff) |-> bus.lock) else $error("swap write not locked");
	pen_cycle_a: assert property (beat_end && pen_ff |=> state_ff == xfer_pkg::st_pen
		##1 state_ff != xfer_pkg::st_pen) else $error("penalty not one cycle");
	slave_mode_a: assert property (slave_test |-> !take ##1 slave_ack == $past(slave_select))
		else $error("slave test mode misbehaved");
endmodule
`default_nettype wire

// ===== rtl/xfer_cfg.svh
// Constants for the processor bus transfer classifier.
`ifndef XFER_CFG_SVH
`define XFER_CFG_SVH
// Length hint encodings.
`define HINT_NONE 2'h0
`define HINT_WB4 2'h1
`define HINT_LINE8 2'h2
`define HINT_SINGLE 2'h3
// Protection encodings for forced-privileged transfers.
`define PROT_PRIV_FETCH 2'h2
`define PROT_PRIV_DATA 2'h3
// Burst geometry.
`define LINE_BEATS 4'h8
`define HALF_BEATS 4'h4
`define HALF_OFFSET 5'h10
`define BEAT_STEP 32'h4
`endif

// ===== rtl/xfer_pkg.sv
// Types shared by the transfer classifier modules.
`default_nettype none
package xfer_pkg;
	// Kinds of transfer the core can ask for.
	typedef enum logic [3:0] {
		k_fetch_nc, k_load_nc, k_store_nb, k_store_b, k_line_i, k_line_d,
		k_evict_lo, k_evict_hi, k_evict_all, k_swap, k_walk_i, k_walk_d
	} xfer_kind_e;
	// Sequencer states.
	typedef enum logic [1:0] {st_idle, st_addr, st_beat, st_pen} seq_state_e;
	// Request from the core.
	typedef struct packed {
		xfer_kind_e kind;
		logic [31:0] addr;
		logic [3:0] nwords;
		logic priv;
	} xfer_req_s;
	// Classification towards the bus.
	typedef struct packed {
		logic address_strobe_out;
		logic [31:0] addr;
		logic write_direction_out;
		logic [1:0] hint;
		logic [1:0] protection_out;
		logic lock;
		logic more_words_pending;
	} bus_out_s;
endpackage
`default_nettype wire

// ===== rtl/beat_addr_gen.sv
// Burst address and beat counter for one transfer.
`default_nettype none
`include "xfer_cfg.svh"
module beat_addr_gen #(
	parameter int CNT_W = 4
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [31:0] base,
	input wire logic [CNT_W-1:0] beats,
	input wire logic step,
	output logic [31:0] addr_ff,
	output logic last
);
	// ************************************************************
	// Counter state
	// ************************************************************
	logic [CNT_W-1:0] rem_ff; // Beats still to go, current included.
	logic [31:0] nxt_addr;
	logic [CNT_W-1:0] nxt_rem;

	// Fewer than four counter bits could not count the eight beats of a line.
	if (CNT_W < 4) begin : g_cnt_check
		$error("beat_addr_gen: CNT_W too small");
	end

	// Loading wins over stepping, so a new transfer never inherits a stale count.
	always_comb begin
		nxt_addr = addr_ff;
		nxt_rem = rem_ff;
		if (load) begin
			nxt_addr = {base[31:2], 2'h0};
			nxt_rem = beats;
		end else if (step && rem_ff > 1) begin
			nxt_addr = addr_ff + `BEAT_STEP;
			nxt_rem = rem_ff - 1'b1;
		end
	end

	// Registers only.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			addr_ff <= 32'h0;
			rem_ff <= '0;
		end else begin
			addr_ff <= nxt_addr;
			rem_ff <= nxt_rem;
		end
	end

	// Last beat flags the end of the burst.
	assign last = (rem_ff <= 1);
endmodule
`default_nettype wire

// ===== test/bus_slave_model.sv
// Behavioural arbiter and slave model on the far side of the bus port.
`default_nettype none
module bus_slave_model (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [1:0] wait_cyc,
	input wire logic gap_en,
	input wire logic lock_in,
	output logic bus_grant_in,
	output logic beat_done_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] cnt_ff; // Wait states spent on the current beat.
	logic [1:0] gcnt_ff; // Arbitration slot counter.
	// With gaps enabled another master takes every fourth slot, but never while
	// the lock is up, so nothing can slip between the two halves of a swap.
	assign bus_grant_in = !(gap_en && !lock_in && gcnt_ff == 2'h3);
	// Slot counter moves on the falling edge, away from the sampling edge.
	always @(negedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			gcnt_ff <= 2'h0;
		end else begin
			gcnt_ff <= gcnt_ff + 2'h1;
		end
	end
	// The slave answers after wait_cyc idle cycles; zero answers at once.
	assign beat_done_in = (cnt_ff == wait_cyc);
	// The counter moves on the falling edge, away from the sampling edge.
	always @(negedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 2'h0;
		end else if (beat_done_in) begin
			cnt_ff <= 2'h0;
		end else begin
			cnt_ff <= cnt_ff + 2'h1;
		end
	end
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for the bus transfer classifier.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, rst_n, req_valid, req_ready, req_done, bus_grant_in, beat_done_in;
	logic wrapper_mode, slave_test, slave_select, slave_ack, strobe_seen, gap_en;
	logic [1:0] wait_cyc; // Slave wait states per beat.
	xfer_pkg::xfer_req_s req;
	xfer_pkg::bus_out_s bus;
	int fails, check_count;
	logic [31:0] aq[$]; // Distinct addresses seen while busy.
	logic mq[$]; // More-words flag beside each distinct address.
	logic [5:0] sq[$]; // Lock, write, hint and protection at each new strobe.

	xfer_classifier dut (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .req_done(req_done), .bus_grant_in(bus_grant_in),
		.beat_done_in(beat_done_in), .wrapper_mode(wrapper_mode), .slave_test(slave_test),
		.slave_select(slave_select), .slave_ack(slave_ack), .bus(bus));
	bus_slave_model partner (.mclk(mclk), .rst_n(rst_n), .wait_cyc(wait_cyc),
		.gap_en(gap_en), .lock_in(bus.lock),
		.bus_grant_in(bus_grant_in), .beat_done_in(beat_done_in));

	// Free-running clock, 40 ns period.
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// Records what the bus shows on each rising edge while a transfer runs.
	always @(posedge mclk) begin
		if (req_ready === 1'b0) begin
			if (aq.size() == 0 || bus.addr !== aq[$]) begin
				aq.push_back(bus.addr);
				mq.push_back(bus.more_words_pending);
			end
			if (bus.address_strobe_out && !strobe_seen) begin
				sq.push_back({bus.lock, bus.write_direction_out, bus.hint, bus.protection_out});
			end
		end
		strobe_seen <= bus.address_strobe_out;
	end

	task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			$display("FAIL %s expected %h seen %h", name, exp, seen);
			fails++;
		end
	endtask

	// One request, then latency, strobe fields and beat addresses are judged.
	// A negative latency skips the cycle count, for runs with a slow slave.
	task automatic xfer(xfer_pkg::xfer_kind_e k, logic [31:0] a, logic [3:0] nw, logic p,
			logic w, int lat, int beats, logic [31:0] base, logic [5:0] s);
		int n;
		aq.delete();
		mq.delete();
		sq.delete();
		req = '{k, a, nw, p};
		wrapper_mode = w;
		req_valid = 1'b1;
		@(negedge mclk);
		req_valid = 1'b0;
		n = 1; // Cycles since the accepting edge.
		while (req_done !== 1'b1 && n < 300) begin
			@(negedge mclk);
			n++;
		end
		if (lat >= 0) chk("latency", n, lat);
		while (req_ready !== 1'b1 && n < 300) begin
			@(negedge mclk);
			n++;
		end
		chk("transfer ended", req_ready, 1);
		chk("strobe fields", sq[0], s);
		chk("beat count", aq.size(), beats);
		for (int i = 0; i < beats; i++) begin
			chk("beat addr", aq[i], base + 32'(4 * i));
			chk("more words", mq[i], i < beats - 1);
		end
	endtask

	// ************
	// Scenarios
	// ************
	task automatic t_reset;
		chk("idle fields", {bus.address_strobe_out, bus.lock, bus.hint, req_done}, 0);
		chk("ready", req_ready, 1);
		$display("reset test done");
	endtask

	task automatic t_stores;
		xfer(xfer_pkg::k_store_b, 32'h80, 4'h1, 1'b1, 1'b0, 1, 1, 32'h80, 6'h1F);
		xfer(xfer_pkg::k_store_nb, 32'h84, 4'h1, 1'b1, 1'b0, 3, 1, 32'h84, 6'h13);
		xfer(xfer_pkg::k_store_nb, 32'h90, 4'h3, 1'b0, 1'b1, 8, 3, 32'h90, 6'h11);
		xfer(xfer_pkg::k_store_b, 32'hA0, 4'h3, 1'b1, 1'b1, 1, 3, 32'hA0, 6'h1F);
		$display("store test done");
	endtask

	task automatic t_reads;
		xfer(xfer_pkg::k_fetch_nc, 32'h40, 4'h1, 1'b0, 1'b0, 3, 1, 32'h40, 6'h00);
		xfer(xfer_pkg::k_load_nc, 32'h44, 4'h1, 1'b1, 1'b1, 3, 1, 32'h44, 6'h03);
		xfer(xfer_pkg::k_load_nc, 32'h50, 4'h4, 1'b1, 1'b0, 6, 4, 32'h50, 6'h03);
		xfer(xfer_pkg::k_line_i, 32'h10C, 4'h0, 1'b1, 1'b0, 10, 8, 32'h100, 6'h0A);
		xfer(xfer_pkg::k_line_d, 32'h204, 4'h0, 1'b0, 1'b1, 10, 8, 32'h200, 6'h09);
		$display("read test done");
	endtask

	task automatic t_evict;
		xfer(xfer_pkg::k_evict_lo, 32'h10C, 4'h0, 1'b0, 1'b0, 6, 4, 32'h100, 6'h17);
		xfer(xfer_pkg::k_evict_hi, 32'h104, 4'h0, 1'b0, 1'b0, 6, 4, 32'h110, 6'h17);
		xfer(xfer_pkg::k_evict_all, 32'h11C, 4'h0, 1'b0, 1'b1, 10, 8, 32'h100, 6'h1B);
		$display("eviction test done");
	endtask

	task automatic t_swap_walk;
		xfer(xfer_pkg::k_swap, 32'h300, 4'h1, 1'b1, 1'b1, 7, 1, 32'h300, 6'h23);
		chk("swap write half", sq[1], 6'h33);
		xfer(xfer_pkg::k_swap, 32'h304, 4'h1, 1'b1, 1'b0, 5, 1, 32'h304, 6'h23);
		xfer(xfer_pkg::k_walk_i, 32'h400, 4'h1, 1'b0, 1'b0, 3, 1, 32'h400, 6'h0E);
		xfer(xfer_pkg::k_walk_d, 32'h404, 4'h1, 1'b0, 1'b0, 3, 1, 32'h404, 6'h0F);
		$display("swap and walk test done");
	endtask

	// Grant gaps and a slow slave stretch each beat; the address order must not change.
	// A locked swap keeps its grant, so its cycle count is unchanged.
	task automatic t_slow;
		gap_en = 1'b1;
		xfer(xfer_pkg::k_swap, 32'h308, 4'h1, 1'b1, 1'b0, 5, 1, 32'h308, 6'h23);
		wait_cyc = 2'h2;
		xfer(xfer_pkg::k_line_d, 32'h51C, 4'h0, 1'b1, 1'b0, -1, 8, 32'h500, 6'h0B);
		wait_cyc = 2'h0;
		gap_en = 1'b0;
		$display("slow slave test done");
	endtask

	task automatic t_slave;
		slave_test = 1'b1;
		slave_select = 1'b1;
		req_valid = 1'b1;
		@(negedge mclk);
		chk("ready in test mode", req_ready, 0);
		@(negedge mclk);
		chk("slave ack", slave_ack, 1);
		chk("no strobe", bus.address_strobe_out, 0);
		req_valid = 1'b0;
		slave_select = 1'b0;
		@(negedge mclk);
		@(negedge mclk);
		chk("slave ack off", slave_ack, 0);
		slave_test = 1'b0;
		@(negedge mclk);
		$display("slave test done");
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Main sequence: reset for ten cycles, then every scenario in turn.
	initial begin
		{rst_n, req_valid, wrapper_mode, slave_test, slave_select} = 5'h0;
		wait_cyc = 2'h0;
		gap_en = 1'b0;
		req = '0;
		repeat (10) @(negedge mclk);
		rst_n = 1'b1;
		@(negedge mclk);
		t_reset();
		t_stores();
		t_reads();
		t_evict();
		t_swap_walk();
		t_slow();
		t_slave();
		report_and_stop();
	end

	// The tests need well under a thousand cycles; this is a generous limit.
	initial begin
		#(40 * 20000);
		fails++;
		$display("watchdog expired");
		report_and_stop();
	end
endmodule
`default_nettype wire
